/* File: hdl/ppt_pkg.sv */
/*
  Package for the protected page tracking block: geometry, page kinds,
  record field positions, command codes and carriers.
  Assumes one core clock and synchronous active-high reset.
*/
`default_nettype none
package ppt_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int SLOTS_PER_PAGE  = 512;
  localparam int SLOT_BYTES      = 8;
  localparam int SLOT_IDX_W      = 9;
  localparam int LAST_SLOT_OFS   = 4088;
  localparam int PAGE_ALIGN      = 4096;
  localparam int INFO_ALIGN      = 32;
  localparam logic [4:0] INFO_STATUS_OFS = 5'h00;
  localparam logic [4:0] INFO_FLAGS_OFS  = 5'h08;
  localparam logic [4:0] INFO_CTX_OFS    = 5'h10;
  // ---------------------------------------------------------------
  // status and flags bit positions
  // ---------------------------------------------------------------
  localparam int ST_CHILD_BIT   = 0;
  localparam int ST_VCHILD_BIT  = 1;
  localparam int FL_READ_BIT    = 0;
  localparam int FL_WRITE_BIT   = 1;
  localparam int FL_EXEC_BIT    = 2;
  localparam int FL_PEND_BIT    = 3;
  localparam int FL_MOD_BIT     = 4;
  localparam int FL_PR_BIT      = 5;
  localparam int FL_KIND_LSB    = 8;
  localparam int FL_BLOCK_BIT   = 63;
  localparam logic [63:0] ZERO64 = 64'h0000000000000000;
  // ---------------------------------------------------------------
  // page kinds and commands
  // ---------------------------------------------------------------
  localparam logic [7:0] control_page_kind        = 8'h00;
  localparam logic [7:0] thread_control_page_kind = 8'h01;
  localparam logic [7:0] ordinary_page_kind       = 8'h02;
  localparam logic [7:0] version_page_kind        = 8'h03;
  localparam logic [7:0] removal_page_kind        = 8'h04;

  typedef enum logic [2:0] {
    PPT_CMD_ADD,
    PPT_CMD_EVICT,
    PPT_CMD_RELOAD,
    PPT_CMD_INFO,
    PPT_CMD_SETST,
    PPT_CMD_REMOVE
  } ppt_cmd_t;

  typedef enum logic [1:0] {
    PPT_OK,
    PPT_ERR_SLOT,
    PPT_ERR_PAGE,
    PPT_ERR_CMD
  } ppt_resp_t;

  typedef struct packed {
    logic       valid;
    logic       rd;
    logic       wr;
    logic       ex;
    logic [7:0] page_kind;
    logic       blocked;
    logic       pending;
    logic       modified;
    logic       permission_restriction_flag;
  } ppt_entry_t;

  typedef struct packed {
    logic [63:0] status;
    logic [63:0] flags;
    logic [63:0] parent_context_pointer;
  } ppt_info_t;
endpackage : ppt_pkg
`default_nettype wire

/* File: hdl/ppt_top.sv */
/*
  Protected page tracking: tracking map for resident pages, version array
  slot storage for evicted pages, and page info record generation.
  Assumes commands come from privileged software as one-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module ppt_top #(
  parameter int PAGES   = 8,
  parameter int VPAGES  = 2,
  parameter int ADDR_W  = 48,
  parameter int VER_W   = 64
) (
  input  wire logic                         CLK_I,
  input  wire logic                         SRST_I,
  input  wire logic                         CE_I,
  input  wire logic                         CMD_VALID_I,
  input  wire ppt_pkg::ppt_cmd_t            CMD_I,
  input  wire logic [$clog2(PAGES)-1:0]     PAGE_I,
  input  wire logic [$clog2(VPAGES)-1:0]    VPAGE_I,
  input  wire logic [ppt_pkg::SLOT_IDX_W-1:0] SLOT_I,
  input  wire logic [VER_W-1:0]             VERSION_I,
  input  wire ppt_pkg::ppt_entry_t          ENTRY_I,
  input  wire logic [63:0]                  OWNER_I,
  input  wire logic [ADDR_W-1:0]            LINADDR_I,
  input  wire logic                         CHILD_I,
  input  wire logic                         VCHILD_I,
  input  wire logic                         GUEST_I,
  output logic                              DONE_O,
  output ppt_pkg::ppt_resp_t                RESP_O,
  output ppt_pkg::ppt_info_t                INFO_O,
  output logic [VER_W-1:0]                  SLOT_DATA_O,
  output logic [ppt_pkg::SLOT_IDX_W+2:0]    SLOT_OFS_O
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam int PW = $clog2(PAGES);
  localparam int SW = ppt_pkg::SLOT_IDX_W;
  localparam int VW = $clog2(VPAGES);

  typedef struct packed {
    ppt_pkg::ppt_entry_t [PAGES-1:0]                 ent;
    logic [PAGES-1:0][63:0]                          owner;
    logic [PAGES-1:0][ADDR_W-1:0]                    lin;
    logic [PAGES-1:0]                                vpage_of;
    logic [VPAGES-1:0][ppt_pkg::SLOTS_PER_PAGE-1:0][VER_W-1:0] ver;
    logic [VPAGES-1:0][ppt_pkg::SLOTS_PER_PAGE-1:0]  used;
    logic                                            done;
    ppt_pkg::ppt_resp_t                              resp;
    ppt_pkg::ppt_info_t                              info;
    logic [VER_W-1:0]                                sdata;
    logic [SW+2:0]                                   sofs;
  } ppt_state_t;

  ppt_state_t s_reg;
  ppt_state_t s_next;
  ppt_pkg::ppt_entry_t e;
  logic [VER_W-1:0]    cur_ver;
  logic                self_slot;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next    = s_reg;
    e         = s_reg.ent[PAGE_I];
    cur_ver   = s_reg.ver[VPAGE_I][SLOT_I];
    // a version page may not hold its own version
    self_slot = (e.page_kind == ppt_pkg::version_page_kind) &&
                s_reg.vpage_of[PAGE_I] &&
                (PAGE_I[VW-1:0] == VPAGE_I);
    s_next.done = 1'b0;
    s_next.sofs = {SLOT_I, 3'h0};  // byte offset 8*n
    s_next.sdata = cur_ver;
    if (CMD_VALID_I) begin
      s_next.done = 1'b1;
      s_next.resp = ppt_pkg::PPT_OK;
      unique case (CMD_I)
        ppt_pkg::PPT_CMD_ADD: begin
          if (e.valid) begin
            s_next.resp = ppt_pkg::PPT_ERR_PAGE;
          end else begin
            s_next.ent[PAGE_I]       = ENTRY_I;
            s_next.ent[PAGE_I].valid = 1'b1;
            s_next.owner[PAGE_I]     = OWNER_I;
            s_next.lin[PAGE_I]       = LINADDR_I;
            s_next.vpage_of[PAGE_I]  = (ENTRY_I.page_kind == ppt_pkg::version_page_kind);
          end
        end
        ppt_pkg::PPT_CMD_EVICT: begin
          if (!e.valid || self_slot) begin
            s_next.resp = ppt_pkg::PPT_ERR_PAGE;
          end else if (s_reg.used[VPAGE_I][SLOT_I]) begin
            s_next.resp = ppt_pkg::PPT_ERR_SLOT;
          end else begin
            s_next.ver[VPAGE_I][SLOT_I]  = VERSION_I;
            s_next.used[VPAGE_I][SLOT_I] = 1'b1;
            s_next.ent[PAGE_I].valid     = 1'b0;
          end
        end
        ppt_pkg::PPT_CMD_RELOAD: begin
          if (e.valid) begin
            s_next.resp = ppt_pkg::PPT_ERR_PAGE;
          end else if (!s_reg.used[VPAGE_I][SLOT_I] || cur_ver != VERSION_I) begin
            s_next.resp = ppt_pkg::PPT_ERR_SLOT;  // slot untouched
          end else begin
            s_next.ver[VPAGE_I][SLOT_I]  = '0;
            s_next.used[VPAGE_I][SLOT_I] = 1'b0;
            s_next.ent[PAGE_I].valid     = 1'b1;
          end
        end
        ppt_pkg::PPT_CMD_INFO: begin
          if (!e.valid) begin
            s_next.resp = ppt_pkg::PPT_ERR_PAGE;
          end else begin
            s_next.info = '0;  // reserved bits zero
            // status field at offset 0
            s_next.info.status[ppt_pkg::ST_CHILD_BIT] =
              (e.page_kind == ppt_pkg::control_page_kind) &&
              (CHILD_I || (GUEST_I && VCHILD_I));
            s_next.info.status[ppt_pkg::ST_VCHILD_BIT] =
              (e.page_kind == ppt_pkg::control_page_kind) &&
              VCHILD_I && !GUEST_I;
            s_next.info.flags[ppt_pkg::FL_READ_BIT]  = e.rd;
            s_next.info.flags[ppt_pkg::FL_WRITE_BIT] = e.wr;
            s_next.info.flags[ppt_pkg::FL_EXEC_BIT]  = e.ex;
            s_next.info.flags[ppt_pkg::FL_PEND_BIT]  = e.pending;
            s_next.info.flags[ppt_pkg::FL_MOD_BIT]   = e.modified;
            s_next.info.flags[ppt_pkg::FL_PR_BIT]    = e.permission_restriction_flag;
            s_next.info.flags[ppt_pkg::FL_BLOCK_BIT] = e.blocked;
            s_next.info.flags[ppt_pkg::FL_KIND_LSB +: 8] = e.page_kind;
            s_next.info.parent_context_pointer = s_reg.owner[PAGE_I];
          end
        end
        ppt_pkg::PPT_CMD_SETST: begin
          if (!e.valid) begin
            s_next.resp = ppt_pkg::PPT_ERR_PAGE;
          end else begin
            s_next.ent[PAGE_I].blocked  = ENTRY_I.blocked;
            s_next.ent[PAGE_I].pending  = ENTRY_I.pending;
            s_next.ent[PAGE_I].modified = ENTRY_I.modified;
            s_next.ent[PAGE_I].permission_restriction_flag =
              ENTRY_I.permission_restriction_flag;
            s_next.ent[PAGE_I].rd = ENTRY_I.rd;
            s_next.ent[PAGE_I].wr = ENTRY_I.wr;
            s_next.ent[PAGE_I].ex = ENTRY_I.ex;
          end
        end
        ppt_pkg::PPT_CMD_REMOVE: begin
          s_next.ent[PAGE_I].valid = 1'b0;
        end
        default: begin
          s_next.resp = ppt_pkg::PPT_ERR_CMD;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers; map never leaves the block
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      s_reg <= '0;
    end else if (CE_I) begin
      s_reg <= s_next;
    end
  end

  assign DONE_O      = s_reg.done;
  assign RESP_O      = s_reg.resp;
  assign INFO_O      = s_reg.info;
  assign SLOT_DATA_O = s_reg.sdata;
  assign SLOT_OFS_O  = s_reg.sofs;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  evict_store_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && CMD_VALID_I && CMD_I == ppt_pkg::PPT_CMD_EVICT && s_next.resp == ppt_pkg::PPT_OK
    |=> s_reg.ver[$past(VPAGE_I)][$past(SLOT_I)] == $past(VERSION_I))
    else $error("evicted version not stored");
  reload_clear_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && CMD_VALID_I && CMD_I == ppt_pkg::PPT_CMD_RELOAD && s_next.resp == ppt_pkg::PPT_OK
    |=> !s_reg.used[$past(VPAGE_I)][$past(SLOT_I)] && s_reg.ent[$past(PAGE_I)].valid)
    else $error("reload did not clear slot");
  reload_reject_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && CMD_VALID_I && CMD_I == ppt_pkg::PPT_CMD_RELOAD && s_reg.used[VPAGE_I][SLOT_I]
    && !s_reg.ent[PAGE_I].valid && cur_ver != VERSION_I
    |=> RESP_O == ppt_pkg::PPT_ERR_SLOT && $stable(s_reg.ver))
    else $error("bad reload accepted");
  slot_offset_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I |=> SLOT_OFS_O == {$past(SLOT_I), 3'h0})
    else $error("slot offset wrong");
  info_kind_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && CMD_VALID_I && CMD_I == ppt_pkg::PPT_CMD_INFO && e.valid
    |=> INFO_O.flags[15:8] == $past(e.page_kind) && INFO_O.flags[62:16] == '0)
    else $error("info kind wrong");
  info_perm_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && CMD_VALID_I && CMD_I == ppt_pkg::PPT_CMD_INFO && e.valid
    |=> INFO_O.flags[2:0] == {$past(e.ex), $past(e.wr), $past(e.rd)})
    else $error("info permissions wrong");
  info_state_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && CMD_VALID_I && CMD_I == ppt_pkg::PPT_CMD_INFO && e.valid
    |=> INFO_O.flags[63] == $past(e.blocked) && INFO_O.flags[7:6] == 2'h0)
    else $error("info state bits wrong");
  guest_vchild_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && CMD_VALID_I && CMD_I == ppt_pkg::PPT_CMD_INFO && e.valid && GUEST_I
    |=> INFO_O.status[1] == 1'b0 && INFO_O.status[63:2] == '0)
    else $error("virtual child bit set in guest");
  child_kind_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && CMD_VALID_I && CMD_I == ppt_pkg::PPT_CMD_INFO && e.valid
    && e.page_kind != ppt_pkg::control_page_kind |=> INFO_O.status[0] == 1'b0)
    else $error("child bit on non-control page");
  self_evict_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && CMD_VALID_I && CMD_I == ppt_pkg::PPT_CMD_EVICT && self_slot
    |=> RESP_O == ppt_pkg::PPT_ERR_PAGE && $stable(s_reg.used))
    else $error("version page stored in itself");
  add_valid_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && CMD_VALID_I && CMD_I == ppt_pkg::PPT_CMD_ADD && !e.valid
    |=> s_reg.ent[$past(PAGE_I)].valid && RESP_O == ppt_pkg::PPT_OK)
    else $error("added page not valid");
  evict_used_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && CMD_VALID_I && CMD_I == ppt_pkg::PPT_CMD_EVICT && e.valid && !self_slot
    && s_reg.used[VPAGE_I][SLOT_I]
    |=> RESP_O == ppt_pkg::PPT_ERR_SLOT && $stable(s_reg.ver))
    else $error("used slot overwritten");
  remove_page_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && CMD_VALID_I && CMD_I == ppt_pkg::PPT_CMD_REMOVE
    |=> !s_reg.ent[$past(PAGE_I)].valid)
    else $error("removed page still valid");
  status_rsvd_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    CE_I && CMD_VALID_I && CMD_I == ppt_pkg::PPT_CMD_INFO && e.valid
    |=> INFO_O.status[63:2] == 62'h0)
    else $error("reserved status bits set");
endmodule : ppt_top
`default_nettype wire

/* File: sim/ppt_sw_model.sv */
/*
  Software-side model: tracks which version slots hold a version and
  offers a free slot for eviction. Assumes it sees the block's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module ppt_sw_model #(
  parameter int VPAGES = 2
) (
  input  wire logic                      clk_i,
  input  wire logic                      srst_i,
  input  wire logic                      take_i,
  input  wire ppt_pkg::ppt_cmd_t         cmd_i,
  input  wire logic [$clog2(VPAGES)-1:0] vpage_i,
  input  wire logic [8:0]                slot_i,
  input  wire logic                      done_i,
  input  wire ppt_pkg::ppt_resp_t        resp_i,
  output logic [8:0]                     free_slot_o
);
  // version pages sit on 4 KB boundaries, slots at base plus 8n
  localparam logic [63:0] VA_BASE   = 64'h0000000000010000;
  // info record buffer on a 32-byte multiple
  localparam logic [63:0] INFO_BASE = 64'h0000000000020020;
  logic [511:0]      used_q [VPAGES];
  ppt_pkg::ppt_cmd_t cmd_q;
  logic [$clog2(VPAGES)-1:0] vp_q;
  logic [8:0]        sl_q;
  always @(posedge clk_i) begin
    if (srst_i) begin
      for (int v = 0; v < VPAGES; v++) used_q[v] <= '0;
    end else begin
      if (take_i) begin
        cmd_q <= cmd_i;
        vp_q  <= vpage_i;
        sl_q  <= slot_i;
      end
      // a filled slot is marked, a reloaded one freed
      if (done_i && resp_i == ppt_pkg::PPT_OK && cmd_q == ppt_pkg::PPT_CMD_EVICT)
        used_q[vp_q][sl_q] <= 1'b1;
      if (done_i && resp_i == ppt_pkg::PPT_OK && cmd_q == ppt_pkg::PPT_CMD_RELOAD)
        used_q[vp_q][sl_q] <= 1'b0;
    end
  end
  // highest empty slot of version page 0 offered, 1FF when none is empty; version pages are never evicted here
  always_comb begin
    free_slot_o = 9'h1FF;
    for (int i = 0; i < 512; i++) if (!used_q[0][i]) free_slot_o = i[8:0];
  end
endmodule // ppt_sw_model
`default_nettype wire

/* File: sim/test_protected_page_tracking.sv */
/*
  Self-checking bench for the page tracking block.
  Assumes default parameters of the block and of the software model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_protected_page_tracking;
  logic CLK_I, SRST_I, CE_I, CMD_VALID_I, CHILD_I, VCHILD_I, GUEST_I, VPAGE_I, DONE_O;
  ppt_pkg::ppt_cmd_t   CMD_I;
  ppt_pkg::ppt_entry_t ENTRY_I;
  ppt_pkg::ppt_resp_t  RESP_O;
  ppt_pkg::ppt_info_t  INFO_O;
  logic [2:0]  PAGE_I;
  logic [8:0]  SLOT_I, free_slot;
  logic [63:0] VERSION_I, OWNER_I, SLOT_DATA_O, lfsr_q, ver_a;
  logic [47:0] LINADDR_I;
  logic [11:0] SLOT_OFS_O;
  logic [7:0]  kinds [5];
  int n_errors = 0;
  int cmp_count = 0;
  int k;
  ppt_top i_ppt_top (.CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I), .CMD_VALID_I(CMD_VALID_I),
    .CMD_I(CMD_I), .PAGE_I(PAGE_I), .VPAGE_I(VPAGE_I), .SLOT_I(SLOT_I), .VERSION_I(VERSION_I),
    .ENTRY_I(ENTRY_I), .OWNER_I(OWNER_I), .LINADDR_I(LINADDR_I), .CHILD_I(CHILD_I),
    .VCHILD_I(VCHILD_I), .GUEST_I(GUEST_I), .DONE_O(DONE_O), .RESP_O(RESP_O), .INFO_O(INFO_O),
    .SLOT_DATA_O(SLOT_DATA_O), .SLOT_OFS_O(SLOT_OFS_O));
  ppt_sw_model i_ppt_sw_model (.clk_i(CLK_I), .srst_i(SRST_I), .take_i(CMD_VALID_I),
    .cmd_i(CMD_I), .vpage_i(VPAGE_I), .slot_i(SLOT_I), .done_i(DONE_O), .resp_i(RESP_O),
    .free_slot_o(free_slot));
  // ---------------------------------------------------------------
  // expectations and checks
  // ---------------------------------------------------------------
  task automatic rnd;
    repeat (17) lfsr_q = {lfsr_q[62:0], lfsr_q[63] ^ lfsr_q[62] ^ lfsr_q[60] ^ lfsr_q[59]};
  endtask
  function automatic logic [63:0] exp_flags(input ppt_pkg::ppt_entry_t e);
    return {e.blocked, 47'h0, e.page_kind, 2'h0, e.permission_restriction_flag,
            e.modified, e.pending, e.ex, e.wr, e.rd};
  endfunction
  function automatic logic [63:0] exp_status(input logic [7:0] kd, input logic c, v, g);
    if (kd !== ppt_pkg::control_page_kind) return 64'h0;
    return {62'h0, v & ~g, c | (v & g)};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_r(input ppt_pkg::ppt_resp_t got, input ppt_pkg::ppt_resp_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmd(input ppt_pkg::ppt_cmd_t c, input logic [2:0] pg, input logic [8:0] sl,
                     input logic [63:0] ver);
    int i;
    @(negedge CLK_I);
    CMD_I = c;
    PAGE_I = pg;
    SLOT_I = sl;
    VERSION_I = ver;
    CMD_VALID_I = 1'b1;
    for (i = 0; i < 4; i++) begin
      @(negedge CLK_I);
      CMD_VALID_I = 1'b0;
      if (DONE_O === 1'b1) break;
    end
    if (i == 4) begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic info(input logic [2:0] pg);
    cmd(ppt_pkg::PPT_CMD_INFO, pg, SLOT_I, 64'h0);
    chk_r(RESP_O, ppt_pkg::PPT_OK);
    chk(INFO_O.status, exp_status(ENTRY_I.page_kind, CHILD_I, VCHILD_I, GUEST_I));
    chk(INFO_O.flags, exp_flags(ENTRY_I));
    chk(INFO_O.parent_context_pointer, OWNER_I);
  endtask
  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  initial begin
    kinds = '{ppt_pkg::control_page_kind, ppt_pkg::thread_control_page_kind,
              ppt_pkg::ordinary_page_kind, ppt_pkg::version_page_kind, ppt_pkg::removal_page_kind};
    {CMD_VALID_I, CHILD_I, VCHILD_I, GUEST_I, VPAGE_I, PAGE_I, SLOT_I} = '0;
    {VERSION_I, OWNER_I, LINADDR_I, ENTRY_I} = '0;
    CMD_I = ppt_pkg::PPT_CMD_ADD;
    CE_I = 1'b1;
    SRST_I = 1'b1;
    lfsr_q = 64'h000000000000005D;
    repeat (3) @(negedge CLK_I);
    SRST_I = 1'b0;
    chk(INFO_O.status | INFO_O.flags | INFO_O.parent_context_pointer, 64'h0);
    for (k = 0; k < 5; k++) begin
      rnd();
      ENTRY_I = lfsr_q[15:0];
      ENTRY_I.valid = 1'b1;
      ENTRY_I.page_kind = kinds[k];
      OWNER_I = lfsr_q ^ 64'h0123456789ABCDEF;
      LINADDR_I = lfsr_q[63:16];
      {CHILD_I, VCHILD_I, GUEST_I} = lfsr_q[20:18];
      cmd(ppt_pkg::PPT_CMD_ADD, k[2:0], 9'h000, 64'h0);
      chk_r(RESP_O, ppt_pkg::PPT_OK);
      info(k[2:0]);
    end
    $display("test add and info done");
    for (k = 0; k < 4; k++) begin
      rnd();
      {ENTRY_I.blocked, ENTRY_I.pending, ENTRY_I.modified} = lfsr_q[2:0];
      ENTRY_I.permission_restriction_flag = lfsr_q[3];
      cmd(ppt_pkg::PPT_CMD_SETST, 3'h4, 9'h000, 64'h0);
      info(3'h4);
    end
    ENTRY_I.page_kind = ppt_pkg::control_page_kind;
    for (k = 0; k < 8; k++) begin
      {CHILD_I, VCHILD_I, GUEST_I} = k[2:0];
      cmd(ppt_pkg::PPT_CMD_INFO, 3'h0, 9'h000, 64'h0);
      chk(INFO_O.status, exp_status(ENTRY_I.page_kind, CHILD_I, VCHILD_I, GUEST_I));
    end
    $display("test state bits and children done");
    cmd(ppt_pkg::PPT_CMD_ADD, 3'h2, 9'h000, 64'h0);
    chk_r(RESP_O, ppt_pkg::PPT_ERR_PAGE);
    rnd();
    ver_a = lfsr_q;
    VPAGE_I = 1'b0;
    cmd(ppt_pkg::PPT_CMD_EVICT, 3'h2, free_slot, ver_a);
    chk_r(RESP_O, ppt_pkg::PPT_OK);
    chk({52'h0, SLOT_OFS_O}, 64'h0000000000000FF8);
    @(negedge CLK_I);
    chk(SLOT_DATA_O, ver_a);
    cmd(ppt_pkg::PPT_CMD_INFO, 3'h2, 9'h1FF, 64'h0);
    chk_r(RESP_O, ppt_pkg::PPT_ERR_PAGE);
    cmd(ppt_pkg::PPT_CMD_EVICT, 3'h3, 9'h1FF, ~ver_a);
    chk_r(RESP_O, ppt_pkg::PPT_ERR_SLOT);
    cmd(ppt_pkg::PPT_CMD_RELOAD, 3'h2, 9'h1FF, ver_a ^ 64'h1);
    chk_r(RESP_O, ppt_pkg::PPT_ERR_SLOT);
    @(negedge CLK_I);
    chk(SLOT_DATA_O, ver_a);
    VPAGE_I = 1'b1;
    cmd(ppt_pkg::PPT_CMD_EVICT, 3'h3, 9'h000, ver_a);
    chk_r(RESP_O, ppt_pkg::PPT_ERR_PAGE);
    cmd(ppt_pkg::PPT_CMD_REMOVE, 3'h1, 9'h000, 64'h0);
    chk_r(RESP_O, ppt_pkg::PPT_OK);
    cmd(ppt_pkg::PPT_CMD_INFO, 3'h1, 9'h000, 64'h0);
    chk_r(RESP_O, ppt_pkg::PPT_ERR_PAGE);
    VPAGE_I = 1'b0;
    cmd(ppt_pkg::PPT_CMD_RELOAD, 3'h2, 9'h1FF, ver_a);
    chk_r(RESP_O, ppt_pkg::PPT_OK);
    $display("test refusals done");
    for (k = 0; k < 8; k++) begin
      rnd();
      VPAGE_I = lfsr_q[9];
      cmd(ppt_pkg::PPT_CMD_EVICT, 3'h2, k == 0 ? 9'h1FF : lfsr_q[8:0], lfsr_q);
      chk_r(RESP_O, ppt_pkg::PPT_OK);
      chk({52'h0, SLOT_OFS_O}, {52'h0, SLOT_I, 3'h0});
      @(negedge CLK_I);
      chk(SLOT_DATA_O, lfsr_q);
      cmd(ppt_pkg::PPT_CMD_RELOAD, 3'h2, SLOT_I, VERSION_I);
      chk_r(RESP_O, ppt_pkg::PPT_OK);
      @(negedge CLK_I);
      chk(SLOT_DATA_O, 64'h0);
    end
    cmd(ppt_pkg::PPT_CMD_RELOAD, 3'h2, 9'h000, 64'h0);
    chk_r(RESP_O, ppt_pkg::PPT_ERR_PAGE);
    $display("test evict and reload done");
    test_done();
  end
endmodule // test_protected_page_tracking
`default_nettype wire
